// ### hdl/wthc_pkg.sv
/*
  Constants, register indices and field layout of the warning threshold and
  hiccup configuration block.
  Assumes a 32-bit AHB-Lite register bus with one aligned word per register.
*/
// Behaviour
// - Overheat select 00 disables the warning; 01, 10, 11 mean 105, 115, 125 degC.
// - Low-input select 0000 is 4.2 V, plus 0.5 V per code; 1111 disables.
// - An enabled threshold that is crossed sets its flag in interrupt status.
// - Sync direction bit 7: 0 makes the sync/mode pin an input, 1 an output.
// - Hiccup bits 3 to 0 per channel: 0 enables hiccup, 1 disables it.
// - A set hiccup-disable bit also disables short-circuit protection of that channel.
// - After power-up, sync direction and all hiccup bits load from factory fuses.
// - Any enabled, set status flag drives the active-low interrupt output low.
// - Flags stay set until software writes 1 or all channel enables are low.
package wthc_pkg;

  localparam int NUM_CH = 4;
  localparam int SYNC_STAGES = 2;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_THRESH = 8'h09;
  localparam logic [7:0] IDX_HICCUP = 8'h0A;
  localparam logic [7:0] IDX_INT_STATUS = 8'h0E;
  localparam logic [7:0] IDX_INT_ENABLE = 8'h0F;
  localparam logic [7:0] IDX_INT_CLEAR = 8'h10;

  localparam int OVH_LSB = 4;
  localparam int OVH_MSB = 5;
  localparam int LVIN_LSB = 0;
  localparam int LVIN_MSB = 3;
  localparam int SYNC_DIR_BIT = 7;
  localparam int HIC_LSB = 0;
  localparam int HIC_MSB = 3;
  localparam int FLAG_OVERHEAT = 5;
  localparam int FLAG_LOW_INPUT = 4;

  localparam logic [7:0] THRESH_RST = 8'h00;
  localparam logic [7:0] HICCUP_RST = 8'h00;
  localparam logic [7:0] INT_ENABLE_RST = 8'h00;
  localparam logic [7:0] INT_LIVE_MASK = 8'h30;

  localparam logic [1:0] OVH_OFF = 2'h0;
  localparam logic [1:0] OVH_105 = 2'h1;
  localparam logic [1:0] OVH_115 = 2'h2;
  localparam logic [7:0] TEMP_105 = 8'h69;
  localparam logic [7:0] TEMP_115 = 8'h73;
  localparam logic [7:0] TEMP_125 = 8'h7D;

  // Input voltage is measured in tenths of a volt.
  localparam logic [3:0] LVIN_OFF = 4'hF;
  localparam logic [7:0] LVIN_BASE_DV = 8'h2A;
  localparam logic [7:0] LVIN_STEP_DV = 8'h05;

  localparam logic [1:0] FUSE_SETTLE = 2'h3;
  localparam logic [1:0] FUSE_LOAD_AT = 2'h1;

  function automatic logic [7:0] overheat_limit(input logic [1:0] sel);
    logic [7:0] lim;
    lim = TEMP_125;
    case (sel)
      OVH_105: lim = TEMP_105;
      OVH_115: lim = TEMP_115;
      default: lim = TEMP_125;
    endcase
    return lim;
  endfunction

  function automatic logic [7:0] low_input_limit(input logic [3:0] sel);
    logic [7:0] prod;
    prod = 8'(LVIN_STEP_DV * {4'h0, sel});
    return 8'(LVIN_BASE_DV + prod);
  endfunction

endpackage

// ### hdl/wthc_sync_if.sv
/*
  Carrier between the block and its input synchroniser: raw and synchronised
  copies of a group of signals.
  Assumes both ends run on the system clock.
*/
`timescale 1ns/1ps
interface wthc_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport src (output raw, input synced);
  modport sync (input raw, output synced);
endinterface

// ### hdl/wthc_sync.sv
/*
  Two flip-flop synchroniser for a group of level inputs.
  Assumes multi-bit groups change slowly enough that a one-cycle skew between
  bits does no harm.
*/
`timescale 1ns/1ps
module wthc_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  wthc_sync_if.sync port
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_stage2;

  always_comb
  begin
    next_stage1 = port.raw;
    next_stage2 = stage1;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      stage1 <= '0;
      stage2 <= '0;
    end
    else
    begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign port.synced = stage2;
endmodule

// ### hdl/wthc_top.sv
/*
  Warning threshold and hiccup configuration registers with the overheat and
  low-input warning flags, their interrupt and an AHB-Lite slave.
  Assumes the measurement, fuse and channel enable inputs are asynchronous
  levels and that the bus master issues single word transfers.
*/
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module wthc_top
  import wthc_pkg::*;
#(
  parameter int CH = wthc_pkg::NUM_CH
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_B_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  input wire logic [7:0] TEMP_MEAS_I,
  input wire logic [7:0] VIN_MEAS_I,
  input wire logic FUSE_SYNC_OUT_I,
  input wire logic FUSE_HICCUP_OFF_I,
  input wire logic [CH-1:0] CHANNEL_ENABLE_INPUTS_I,
  output logic SYNC_DIR_OUT_O,
  output logic [CH-1:0] HICCUP_DISABLE_O,
  output logic [CH-1:0] SCP_DISABLE_O,
  output logic INT_B_O
);
  import wthc_pkg::*;

  wthc_sync_if #(.W(16)) meas_if ();
  wthc_sync_if #(.W(2)) fuse_if ();
  wthc_sync_if #(.W(CH)) chen_if ();

  assign meas_if.raw = {TEMP_MEAS_I, VIN_MEAS_I};
  assign fuse_if.raw = {FUSE_SYNC_OUT_I, FUSE_HICCUP_OFF_I};
  assign chen_if.raw = CHANNEL_ENABLE_INPUTS_I;

  wthc_sync #(.W(16)) u_meas_sync (
    .clk_i(CLK_SYS_I),
    .rst_b_i(RST_B_I),
    .port(meas_if.sync)
  );

  wthc_sync #(.W(2)) u_fuse_sync (
    .clk_i(CLK_SYS_I),
    .rst_b_i(RST_B_I),
    .port(fuse_if.sync)
  );

  wthc_sync #(.W(CH)) u_chen_sync (
    .clk_i(CLK_SYS_I),
    .rst_b_i(RST_B_I),
    .port(chen_if.sync)
  );

  logic [15:0] meas_hold;
  logic [15:0] next_meas_hold;
  logic meas_steady;
  logic [7:0] temp_s;
  logic [7:0] vin_s;
  logic fuse_sync_s;
  logic fuse_hic_s;
  logic en_any;

  assign temp_s = meas_hold[15:8];
  assign vin_s = meas_hold[7:0];
  // The measurement words cross bit by bit, so a value is trusted only once two samples agree.
  assign meas_steady = (meas_if.synced == meas_hold);
  assign fuse_sync_s = fuse_if.synced[1];
  assign fuse_hic_s = fuse_if.synced[0];
  assign en_any = |chen_if.synced;

  // Bus data phase state and register file.
  logic dp_write;
  logic [7:0] dp_idx;
  logic [7:0] thresh_cfg;
  logic [7:0] hiccup_cfg;
  logic [7:0] int_status;
  logic [7:0] int_enable;
  logic [1:0] load_cnt;
  logic [31:0] hrdata;
  logic int_b;
  logic hreadyout;
  logic hresp;

  logic next_dp_write;
  logic [7:0] next_dp_idx;
  logic [7:0] next_thresh_cfg;
  logic [7:0] next_hiccup_cfg;
  logic [7:0] next_int_status;
  logic [7:0] next_int_enable;
  logic [1:0] next_load_cnt;
  logic [31:0] next_hrdata;
  logic next_int_b;
  logic next_hreadyout;
  logic next_hresp;

  logic addr_phase;
  logic addr_in_map;
  logic [7:0] addr_idx;
  logic wr_thresh;
  logic wr_hiccup;
  logic wr_enable;
  logic wr_clear;
  logic ovh_event;
  logic low_event;
  logic [7:0] set_bits;
  logic [7:0] clr_bits;
  logic [1:0] ovh_sel;
  logic [3:0] lvin_sel;

  always_comb
  begin
    addr_phase = HSEL_I && HTRANS_I[1] && HREADY_I;
    addr_in_map = (HADDR_I[31:10] == 22'h000000) && (HADDR_I[1:0] == 2'h0);
    addr_idx = HADDR_I[9:2];
    wr_thresh = dp_write && (dp_idx == IDX_THRESH);
    wr_hiccup = dp_write && (dp_idx == IDX_HICCUP);
    wr_enable = dp_write && (dp_idx == IDX_INT_ENABLE);
    wr_clear = dp_write && (dp_idx == IDX_INT_CLEAR);
    ovh_sel = thresh_cfg[OVH_MSB:OVH_LSB];
    lvin_sel = thresh_cfg[LVIN_MSB:LVIN_LSB];
    // Warnings only fire for an enabled threshold that the measurement has passed.
    ovh_event = meas_steady && (ovh_sel != OVH_OFF) && (temp_s > overheat_limit(ovh_sel));
    low_event = meas_steady && (lvin_sel != LVIN_OFF) && (vin_s < low_input_limit(lvin_sel));
    set_bits = '0;
    set_bits[FLAG_OVERHEAT] = ovh_event;
    set_bits[FLAG_LOW_INPUT] = low_event;
    clr_bits = wr_clear ? HWDATA_I[7:0] : 8'h00;
  end

  always_comb
  begin
    next_dp_write = addr_phase && HWRITE_I && addr_in_map;
    next_dp_idx = addr_phase ? addr_idx : dp_idx;
    next_thresh_cfg = wr_thresh ? HWDATA_I[7:0] : thresh_cfg;
    next_hiccup_cfg = wr_hiccup ? HWDATA_I[7:0] : hiccup_cfg;
    next_int_enable = wr_enable ? (HWDATA_I[7:0] & INT_LIVE_MASK) : int_enable;
    next_load_cnt = (load_cnt != 2'h0) ? (load_cnt - 2'h1) : load_cnt;
    next_meas_hold = meas_if.synced;
    // Ready and response are registered constants, so every bus output leaves a flop.
    next_hreadyout = 1'b1;
    next_hresp = 1'b0;
    // Fuses are sampled once, after the synchroniser has filled.
    if (load_cnt == FUSE_LOAD_AT)
    begin
      next_hiccup_cfg = HICCUP_RST;
      next_hiccup_cfg[SYNC_DIR_BIT] = fuse_sync_s;
      next_hiccup_cfg[HIC_MSB:HIC_LSB] = {CH{fuse_hic_s}};
    end
    // A fresh event beats a software clear, but no enabled channel clears everything.
    if (!en_any)
    begin
      next_int_status = 8'h00;
    end
    else
    begin
      next_int_status = ((int_status & ~clr_bits) | set_bits) & INT_LIVE_MASK;
    end
    next_int_b = ~|(next_int_status & next_int_enable);
  end

  // Read data is taken from the next values so a read right behind a write sees it.
  always_comb
  begin
    next_hrdata = 32'h00000000;
    if (addr_phase && !HWRITE_I && addr_in_map)
    begin
      case (addr_idx)
        IDX_THRESH: next_hrdata[7:0] = next_thresh_cfg;
        IDX_HICCUP: next_hrdata[7:0] = next_hiccup_cfg;
        IDX_INT_STATUS: next_hrdata[7:0] = next_int_status;
        IDX_INT_ENABLE: next_hrdata[7:0] = next_int_enable;
        default: next_hrdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_B_I)
    begin
      dp_write <= 1'b0;
      dp_idx <= 8'h00;
      thresh_cfg <= THRESH_RST;
      hiccup_cfg <= HICCUP_RST;
      int_status <= 8'h00;
      int_enable <= INT_ENABLE_RST;
      load_cnt <= FUSE_SETTLE;
      hrdata <= 32'h00000000;
      int_b <= 1'b1;
      meas_hold <= 16'h0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      dp_write <= next_dp_write;
      dp_idx <= next_dp_idx;
      thresh_cfg <= next_thresh_cfg;
      hiccup_cfg <= next_hiccup_cfg;
      int_status <= next_int_status;
      int_enable <= next_int_enable;
      load_cnt <= next_load_cnt;
      hrdata <= next_hrdata;
      int_b <= next_int_b;
      meas_hold <= next_meas_hold;
      hreadyout <= next_hreadyout;
      hresp <= next_hresp;
    end
  end

  // The slave never stalls and never errors; ready stays high through reset as well.
  assign HRDATA_O = hrdata;
  assign HREADYOUT_O = hreadyout;
  assign HRESP_O = hresp;
  assign SYNC_DIR_OUT_O = hiccup_cfg[SYNC_DIR_BIT];
  assign HICCUP_DISABLE_O = hiccup_cfg[HIC_MSB:HIC_LSB];
  // Short-circuit protection follows hiccup directly, with no register of its own.
  assign SCP_DISABLE_O = hiccup_cfg[HIC_MSB:HIC_LSB];
  assign INT_B_O = int_b;

  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RST_B_I);

  chk_ovh_off_quiet: assert property (
    (ovh_sel == OVH_OFF) && !int_status[FLAG_OVERHEAT] && !wr_thresh |=> !int_status[FLAG_OVERHEAT])
    else $error("overheat flag set while warning disabled");

  chk_ovh_105_trip: assert property (
    meas_steady && (ovh_sel == 2'h1) && (temp_s > 8'h69) && en_any |=> int_status[FLAG_OVERHEAT])
    else $error("overheat above 105 degC not flagged");

  chk_lvin_top_trip: assert property (
    meas_steady && (lvin_sel == 4'hE) && (vin_s < 8'h70) && en_any |=> int_status[FLAG_LOW_INPUT])
    else $error("low input below 11.2 V not flagged");

  chk_lvin_off_quiet: assert property (
    (lvin_sel == 4'hF) && !int_status[FLAG_LOW_INPUT] && !wr_thresh |=> !int_status[FLAG_LOW_INPUT])
    else $error("low input flag set while warning disabled");

  chk_flag_sticky: assert property (
    int_status[FLAG_OVERHEAT] && !wr_clear && en_any |=> int_status[FLAG_OVERHEAT])
    else $error("overheat flag dropped without a clear");

  chk_enables_clear: assert property (
    !en_any |=> (int_status == 8'h00) && INT_B_O)
    else $error("flags not cleared with all channels disabled");

  chk_sync_dir_write: assert property (
    wr_hiccup && (load_cnt != FUSE_LOAD_AT) |=> SYNC_DIR_OUT_O == $past(HWDATA_I[7]))
    else $error("sync direction does not follow write");

  chk_scp_follows: assert property (
    wr_hiccup && (load_cnt != FUSE_LOAD_AT) |=> (SCP_DISABLE_O == $past(HWDATA_I[3:0]))
      && (HICCUP_DISABLE_O == SCP_DISABLE_O))
    else $error("short-circuit disable does not track hiccup disable");

  chk_fuse_load: assert property (
    load_cnt == FUSE_LOAD_AT |=> (HICCUP_DISABLE_O == {CH{$past(fuse_hic_s)}})
      && (SYNC_DIR_OUT_O == $past(fuse_sync_s)))
    else $error("fuse defaults not loaded");

  chk_int_low: assert property (
    |(int_status & int_enable) && en_any && !wr_clear && !wr_enable |=> !INT_B_O)
    else $error("interrupt output not low with enabled flag");

  chk_reserved_rw: assert property (
    wr_thresh |=> thresh_cfg == $past(HWDATA_I[7:0]))
    else $error("threshold register does not hold written value");

  chk_skew_guard: assert property (
    !meas_steady && en_any && !wr_clear |=> int_status == $past(int_status))
    else $error("status changed while measurement unsettled");

  chk_ovh_125_trip: assert property (
    meas_steady && (ovh_sel == 2'h3) && (temp_s > 8'h7D) && en_any |=> int_status[FLAG_OVERHEAT])
    else $error("overheat above 125 degC not flagged");

  chk_lvin_base_trip: assert property (
    meas_steady && (lvin_sel == 4'h0) && (vin_s < 8'h2A) && en_any |=> int_status[FLAG_LOW_INPUT])
    else $error("low input below 4.2 V not flagged");

  chk_clear_bit: assert property (
    wr_clear && HWDATA_I[FLAG_LOW_INPUT] && !low_event && en_any |=> !int_status[FLAG_LOW_INPUT])
    else $error("low input flag not cleared by write of one");

  chk_set_beats_clear: assert property (
    wr_clear && HWDATA_I[FLAG_OVERHEAT] && ovh_event && en_any |=> int_status[FLAG_OVERHEAT])
    else $error("overheat flag lost to a clear while the condition holds");

  cov_ovh_flag: cover property (!int_status[FLAG_OVERHEAT] ##1 int_status[FLAG_OVERHEAT]);
  cov_low_flag: cover property (!int_status[FLAG_LOW_INPUT] ##1 int_status[FLAG_LOW_INPUT]);
  cov_sw_clear: cover property (wr_clear && int_status[FLAG_OVERHEAT] ##1 !int_status[FLAG_OVERHEAT]);
  cov_int_fire: cover property (INT_B_O ##1 !INT_B_O);
  cov_set_wins: cover property (wr_clear && ovh_event ##1 int_status[FLAG_OVERHEAT]);
endmodule

// ### verif/wthc_top_tb.sv
/*
  Self-checking bench for the warning threshold and hiccup configuration block.
  Assumes wthc_pkg and the design files are compiled first and that one AHB-Lite slave owns the bus.
*/
`timescale 1ns/1ps
module wthc_top_tb;
  import wthc_pkg::*;
  typedef struct packed {logic [7:0] idx; logic [7:0] wd; logic [7:0] rd; logic sy; logic [3:0] hc;} wthc_row_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] temp = 8'h19;
  logic [7:0] vin = 8'h78;
  logic f_sync = 1'b1;
  logic f_hic = 1'b1;
  logic [3:0] ch_en = 4'hF;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic sync_dir;
  logic [3:0] hic_dis;
  logic [3:0] scp_dis;
  logic int_b;
  logic [31:0] rd;
  logic [7:0] vl;
  logic [7:0] tlim [4] = '{8'h00, 8'h69, 8'h73, 8'h7D};
  wthc_row_t rows [13];
  int n_errors = 0;
  int n_checks = 0;

  always #2.5 clk = ~clk;

  wthc_top u_wthc_top (.CLK_SYS_I(clk), .RST_B_I(rst_b), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
    .HREADYOUT_O(hready), .HRESP_O(hresp), .TEMP_MEAS_I(temp), .VIN_MEAS_I(vin), .FUSE_SYNC_OUT_I(f_sync),
    .FUSE_HICCUP_OFF_I(f_hic), .CHANNEL_ENABLE_INPUTS_I(ch_en), .SYNC_DIR_OUT_O(sync_dir),
    .HICCUP_DISABLE_O(hic_dis), .SCP_DISABLE_O(scp_dis), .INT_B_O(int_b));

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask

  // Single word transfer; the master waits on hready, so wait states would be tolerated.
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {24'h0, wd};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
    check("hresp", 32'h0, 32'(hresp));
  endtask

  task automatic rdchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    check(what, {24'h0, exp}, rd);
  endtask

  // Six cycles cover the two-flop synchroniser, the flag and the interrupt flop.
  task automatic settle(input logic [7:0] t, input logic [7:0] v);
    temp <= t;
    vin <= v;
    repeat (6) @(posedge clk);
  endtask

  task automatic warn(input logic [7:0] thr, input logic [7:0] tq, input logic [7:0] vq,
                      input logic [7:0] tt, input logic [7:0] vt, input logic [7:0] fl);
    bus(1'b1, IDX_THRESH, thr);
    settle(tq, vq);
    rdchk("status at limit", IDX_INT_STATUS, 8'h00);
    settle(tt, vt);
    rdchk("status tripped", IDX_INT_STATUS, fl);
    check("int_b tripped", 32'(fl == 8'h00), 32'(int_b));
    settle(8'h19, 8'h78);
    rdchk("status held", IDX_INT_STATUS, fl);
    bus(1'b1, IDX_INT_CLEAR, fl);
    rdchk("status cleared", IDX_INT_STATUS, 8'h00);
    repeat (2) @(posedge clk);
    check("int_b cleared", 32'h1, 32'(int_b));
  endtask

  task automatic do_reset(input logic fs, input logic fh);
    f_sync <= fs;
    f_hic <= fh;
    rst_b <= 1'b0;
    repeat (8) @(posedge clk);
    check("sync in reset", 32'h0, 32'(sync_dir));
    check("hiccup in reset", 32'h0, 32'(hic_dis));
    check("int_b in reset", 32'h1, 32'(int_b));
    check("hready in reset", 32'h1, 32'(hready));
    check("hrdata in reset", 32'h0, hrdata);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    rdchk("hiccup fuse", IDX_HICCUP, {fs, 3'h0, {4{fh}}});
    check("sync fuse", 32'(fs), 32'(sync_dir));
    check("hiccup out fuse", 32'({4{fh}}), 32'(hic_dis));
    check("scp out fuse", 32'({4{fh}}), 32'(scp_dis));
    rdchk("thresh reset", IDX_THRESH, 8'h00);
    rdchk("enable reset", IDX_INT_ENABLE, 8'h00);
    rdchk("status reset", IDX_INT_STATUS, 8'h00);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    summarize();
  end

  initial
  begin
    rows = '{'{8'h09, 8'hFF, 8'hFF, 1'b1, 4'hF}, '{8'h09, 8'h00, 8'h00, 1'b1, 4'hF},
      '{8'h0A, 8'h01, 8'h01, 1'b0, 4'h1}, '{8'h0A, 8'h02, 8'h02, 1'b0, 4'h2},
      '{8'h0A, 8'h04, 8'h04, 1'b0, 4'h4}, '{8'h0A, 8'h08, 8'h08, 1'b0, 4'h8},
      '{8'h0A, 8'hF0, 8'hF0, 1'b1, 4'h0}, '{8'h0A, 8'h7F, 8'h7F, 1'b0, 4'hF},
      '{8'h11, 8'hFF, 8'h00, 1'b0, 4'hF}, '{8'h10, 8'hFF, 8'h00, 1'b0, 4'hF},
      '{8'h0F, 8'hFF, 8'h30, 1'b0, 4'hF}, '{8'h0E, 8'hFF, 8'h00, 1'b0, 4'hF},
      '{8'h0A, 8'h00, 8'h00, 1'b0, 4'h0}};
    do_reset(1'b1, 1'b1);
    foreach (rows[i])
    begin
      bus(1'b1, rows[i].idx, rows[i].wd);
      rdchk($sformatf("row %0d readback", i), rows[i].idx, rows[i].rd);
      check($sformatf("row %0d sync", i), 32'(rows[i].sy), 32'(sync_dir));
      check($sformatf("row %0d hiccup", i), 32'(rows[i].hc), 32'(hic_dis));
      check($sformatf("row %0d scp", i), 32'(rows[i].hc), 32'(scp_dis));
    end
    for (int s = 1; s < 4; s++)
      warn({2'h0, 2'(s), 4'hF}, tlim[s], 8'h78, tlim[s] + 8'h01, 8'h78, 8'h20);
    for (int c = 0; c < 15; c++)
    begin
      vl = 8'h2A + 8'h05 * 8'(c);
      warn({4'h0, 4'(c)}, 8'h19, vl, 8'h19, vl - 8'h01, 8'h10);
    end
    warn(8'h0F, 8'h19, 8'h78, 8'hFF, 8'h00, 8'h00);
    bus(1'b1, IDX_INT_ENABLE, 8'h00);
    bus(1'b1, IDX_THRESH, 8'h10);
    settle(8'hFF, 8'h20);
    settle(8'h19, 8'h78);
    rdchk("both flags", IDX_INT_STATUS, 8'h30);
    check("int_b masked", 32'h1, 32'(int_b));
    bus(1'b1, IDX_INT_ENABLE, 8'h20);
    repeat (2) @(posedge clk);
    check("int_b enabled", 32'h0, 32'(int_b));
    bus(1'b1, IDX_INT_CLEAR, 8'h20);
    rdchk("one cleared", IDX_INT_STATUS, 8'h10);
    check("int_b after clear", 32'h1, 32'(int_b));
    settle(8'hFF, 8'h78);
    bus(1'b1, IDX_INT_CLEAR, 8'h20);
    rdchk("set beats clear", IDX_INT_STATUS, 8'h30);
    settle(8'h19, 8'h78);
    ch_en <= 4'h0;
    repeat (6) @(posedge clk);
    rdchk("enables low", IDX_INT_STATUS, 8'h00);
    ch_en <= 4'hF;
    do_reset(1'b1, 1'b0);
    summarize();
  end
endmodule
